/* design/shb_classifier_pkg.sv */
// shared constants, types and boundary tables for the high-band frame classifier
//Contract
//[RULE1] transient flag forces TRANSIENT, skips other decisions
//[RULE2] nine bands of 32 over 288 coefficients
//[RULE3] sharpness is 31 peak over (sum minus peak)
//[RULE4] band peak is largest magnitude in band
//[RULE5] energy, mean magnitude and spread per frame
//[RULE6] maximum sharpness is largest band peak
//[RULE7] sharp count: sharpness over 4.5, peak over 8
//[RULE8] noise count: sharpness below 3
//[RULE9] harmonic count threshold from history
//[RULE10] peak threshold 10, 5 or 20
//[RULE11] harmonic test raises persistence up to twelve
//[RULE12] failed test lowers persistence toward zero
//[RULE13] persistence two or more forces HARMONIC
//[RULE14] NOISE test else NORMAL
//[RULE15] class codes 00 01 10 11
//[RULE16] class saved for next frame
//[RULE17] window offset 6 or 80 by rate
//[RULE18] transient sub-bands 0,76,152,236,320
//[RULE19] fourteen normal sub-bands up to 320
//[RULE20] index belongs to band by start bounds
//[RULE21] upstream gives one transient flag per frame
//[RULE22] reset clears history, stream uses valid/ready
//[RULE23] energy ratio by cross-multiply, zero fails
package shb_classifier_pkg;

    localparam int COEF_W = 16;
    localparam int MAG_W = 16;
    localparam int IDX_W = 9;
    localparam int BAND_SUM_W = 21;
    localparam int TOTAL_W = 24;
    localparam int ENERGY_W = 40;
    localparam int SPREAD_W = 32;
    localparam int PERSIST_W = 4;
    localparam int CNT_W = 4;

    localparam logic [IDX_W-1:0] FRAME_LEN = 9'd320;
    localparam logic [IDX_W-1:0] CLASS_LEN = 9'd288;
    localparam logic [4:0] BAND_LAST_POS = 5'd31;
    localparam logic [3:0] NUM_BANDS = 4'd9;

    // sharpness > 4.5  <=>  62*peak > 9*(sum-peak)
    localparam logic [6:0] SHARP_PEAK_MUL = 7'd62;
    localparam logic [6:0] SHARP_REST_MUL = 7'd9;
    // sharpness < 3  <=>  31*peak < 3*(sum-peak)
    localparam logic [6:0] NOISE_PEAK_MUL = 7'd31;
    localparam logic [6:0] NOISE_REST_MUL = 7'd3;
    localparam logic [MAG_W-1:0] SHARP_PEAK_MIN = 16'h0008;

    localparam logic [CNT_W-1:0] ISHARP_SWB_HARM = 4'h4;
    localparam logic [CNT_W-1:0] ISHARP_SWB_TRANS = 4'h8;
    localparam logic [CNT_W-1:0] ISHARP_SWB_OTHER = 4'h6;
    localparam logic [CNT_W-1:0] ISHARP_CHG_HARM = 4'h2;
    localparam logic [CNT_W-1:0] ISHARP_CHG_OTHER = 4'h8;
    localparam logic [MAG_W-1:0] LSHARP_SWB = 16'h000a;
    localparam logic [MAG_W-1:0] LSHARP_HARM = 16'h0005;
    localparam logic [MAG_W-1:0] LSHARP_OTHER = 16'h0014;

    // 0.5 < g/gp < 1.8  <=>  2g > gp  and  5g < 9gp
    localparam logic [3:0] RATIO_LO_MUL = 4'h2;
    localparam logic [3:0] RATIO_HI_CUR = 4'h5;
    localparam logic [3:0] RATIO_HI_PREV = 4'h9;

    localparam logic [PERSIST_W-1:0] PERSIST_MAX = 4'hc;
    localparam logic [PERSIST_W-1:0] PERSIST_FORCE = 4'h2;

    // spread scaled by 288: sum |9*band_sum - total|; 4.8*mean => 5*spread < 24*total
    localparam logic [3:0] SPREAD_BAND_MUL = 4'h9;
    localparam logic [3:0] SPREAD_MUL = 4'h5;
    localparam logic [4:0] MEAN_MUL = 5'h18;
    localparam logic [CNT_W-1:0] NOISE_BANDS_MIN = 4'h4;
    // tilt is signed q8.8
    localparam logic signed [15:0] TILT_LIMIT = 16'sh0500;

    localparam logic [6:0] OFFSET_13K2 = 7'h06;
    localparam logic [6:0] OFFSET_32K = 7'h50;

    localparam logic [3:0] SB_COUNT_TRANS = 4'h4;
    localparam logic [3:0] SB_COUNT_NORMAL = 4'he;
    localparam logic [IDX_W-1:0] SB_TRANS_START [0:3] = '{9'd0, 9'd76, 9'd152, 9'd236};
    localparam logic [IDX_W-1:0] SB_NORM_START [0:13] = '{9'd0, 9'd16, 9'd40, 9'd56, 9'd80, 9'd96,
        9'd120, 9'd136, 9'd160, 9'd184, 9'd208, 9'd232, 9'd256, 9'd288};

    typedef enum logic [1:0] {
        CLASS_NOISE = 2'b00,
        CLASS_TRANSIENT = 2'b01,
        CLASS_NORMAL = 2'b10,
        CLASS_HARMONIC = 2'b11
    } class_t;

    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_ENERGY_LO = 8'h08;
    localparam logic [7:0] ADDR_ENERGY_HI = 8'h0c;
    localparam logic [7:0] ADDR_PEAK = 8'h10;
    localparam logic [7:0] ADDR_SPREAD = 8'h14;
    localparam logic [7:0] ADDR_FRAMES = 8'h18;
    localparam int CTRL_RATE_BIT = 0;
    localparam int CTRL_PREV_SWB_BIT = 1;
    localparam int CTRL_CLEAR_BIT = 2;
    localparam logic [1:0] CTRL_RESET = 2'b00;

    // start of sub-band j; j at or past the band count gives the frame end
    function automatic logic [IDX_W-1:0] sb_start(input logic trans, input logic [3:0] j);
        if (trans) begin
            sb_start = (j < SB_COUNT_TRANS) ? SB_TRANS_START[j[1:0]] : FRAME_LEN; // [RULE18]
        end else begin
            sb_start = (j < SB_COUNT_NORMAL) ? SB_NORM_START[j] : FRAME_LEN; // [RULE19]
        end
    endfunction : sb_start

endpackage : shb_classifier_pkg

/* design/band_sharpness.sv */
// sharp and noise tests of one 32-coefficient band, free of division
module band_sharpness
    import shb_classifier_pkg::*;
(
    input logic [MAG_W-1:0] peak,
    input logic [BAND_SUM_W-1:0] sum,
    output logic is_sharp,
    output logic is_noisy
);

    logic [BAND_SUM_W-1:0] rest;
    logic [BAND_SUM_W+6:0] peak_sharp;
    logic [BAND_SUM_W+6:0] rest_sharp;
    logic [BAND_SUM_W+6:0] peak_noise;
    logic [BAND_SUM_W+6:0] rest_noise;

    // peak is part of sum: rest stays positive
    assign rest = sum - BAND_SUM_W'(peak);
    assign peak_sharp = (BAND_SUM_W+7)'(peak) * (BAND_SUM_W+7)'(SHARP_PEAK_MUL);
    assign rest_sharp = (BAND_SUM_W+7)'(rest) * (BAND_SUM_W+7)'(SHARP_REST_MUL);
    assign peak_noise = (BAND_SUM_W+7)'(peak) * (BAND_SUM_W+7)'(NOISE_PEAK_MUL);
    assign rest_noise = (BAND_SUM_W+7)'(rest) * (BAND_SUM_W+7)'(NOISE_REST_MUL);

    // empty band: sharpness zero, so noisy
    assign is_sharp = (sum != '0) && (peak_sharp > rest_sharp) && (peak > SHARP_PEAK_MIN); // [RULE3] [RULE7]
    assign is_noisy = (sum == '0) || (peak_noise < rest_noise); // [RULE3] [RULE8]

endmodule : band_sharpness

/* design/shb_frame_classifier.sv */
// per-frame high-band classifier with apb status and sub-band boundary lookup
module shb_frame_classifier
    import shb_classifier_pkg::*;
(
    input logic clk,
    input logic rstn,
    input logic psel,
    input logic penable,
    input logic pwrite,
    input logic [7:0] paddr,
    input logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input logic in_valid,
    output logic in_ready,
    input logic signed [COEF_W-1:0] in_coef,
    input logic transient_flag,
    input logic signed [15:0] in_tilt,
    output logic class_valid,
    output logic [1:0] class_code,
    output logic [6:0] hb_offset,
    output logic [3:0] sb_count,
    input logic [3:0] bound_sel,
    output logic [IDX_W-1:0] bound_start,
    output logic [IDX_W-1:0] bound_end,
    input logic [IDX_W-1:0] map_k,
    output logic [3:0] map_band
);

    typedef enum logic [1:0] {ST_ACCUM, ST_SPREAD, ST_DECIDE} state_t;

    state_t state_reg;
    logic [IDX_W-1:0] idx_reg;
    logic [MAG_W-1:0] band_peak_reg;
    logic [BAND_SUM_W-1:0] band_sum_reg;
    logic [BAND_SUM_W-1:0] band_sums [0:8];
    logic [TOTAL_W-1:0] total_reg;
    logic [ENERGY_W-1:0] energy_reg;
    logic [MAG_W-1:0] kmax_reg;
    logic [CNT_W-1:0] sharp_cnt_reg;
    logic [CNT_W-1:0] noise_cnt_reg;
    logic [3:0] spread_idx_reg;
    logic [SPREAD_W-1:0] spread_reg;
    logic frame_transient_reg;
    logic signed [15:0] frame_tilt_reg;
    logic [PERSIST_W-1:0] persist_reg;
    class_t prev_class_reg;
    logic [ENERGY_W-1:0] prev_energy_reg;
    logic [1:0] ctrl_reg;
    logic [31:0] frames_reg;
    logic last_trans_reg;

    logic in_fire;
    logic band_first;
    logic in_class_range;
    logic band_done;
    logic frame_done;
    logic [MAG_W-1:0] mag;
    logic [MAG_W-1:0] band_peak_next;
    logic [BAND_SUM_W-1:0] band_sum_next;
    logic [2*COEF_W-1:0] square;
    logic band_is_sharp;
    logic band_is_noisy;
    logic [SPREAD_W-1:0] spread_term;
    logic [CNT_W-1:0] isharp;
    logic [MAG_W-1:0] lsharp;
    logic ratio_ok;
    logic harm_hit;
    logic noise_hit;
    logic [PERSIST_W-1:0] persist_next;
    class_t class_next;
    logic apb_setup;
    logic apb_write;
    logic addr_ok;
    logic hist_clear;

    function automatic logic [MAG_W-1:0] magnitude(input logic signed [COEF_W-1:0] c);
        magnitude = c[COEF_W-1] ? MAG_W'(-c) : MAG_W'(c);
    endfunction : magnitude

    function automatic logic [MAG_W-1:0] max_mag(input logic [MAG_W-1:0] a, input logic [MAG_W-1:0] b);
        max_mag = (a > b) ? a : b;
    endfunction : max_mag

    // one 320-beat frame; flag and tilt on beat 0
    assign in_ready = (state_reg == ST_ACCUM); // [RULE22]
    assign in_fire = in_valid && in_ready;
    assign frame_done = in_fire && (idx_reg == FRAME_LEN - 9'd1);
    assign band_first = (idx_reg[4:0] == 5'd0);
    assign in_class_range = (idx_reg < CLASS_LEN); // [RULE2]
    assign band_done = in_fire && in_class_range && (idx_reg[4:0] == BAND_LAST_POS); // [RULE2]
    assign mag = magnitude(in_coef);
    assign square = 32'(in_coef) * 32'(in_coef);
    assign band_peak_next = max_mag(band_first ? '0 : band_peak_reg, mag); // [RULE4]
    assign band_sum_next = (band_first ? '0 : band_sum_reg) + BAND_SUM_W'(mag);

    band_sharpness u_sharp (
        .peak(band_peak_next),
        .sum(band_sum_next),
        .is_sharp(band_is_sharp),
        .is_noisy(band_is_noisy)
    );

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            idx_reg <= '0;
        end else if (frame_done) begin
            idx_reg <= '0;
        end else if (in_fire) begin
            idx_reg <= idx_reg + 9'd1;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            frame_transient_reg <= 1'b0;
            frame_tilt_reg <= '0;
        end else if (in_fire && idx_reg == '0) begin
            frame_transient_reg <= transient_flag; // [RULE21]
            frame_tilt_reg <= in_tilt;
        end
    end

    // band peak and sum; only the sum is latched into the per-band store at band end
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            band_peak_reg <= '0;
            band_sum_reg <= '0;
        end else if (in_fire && in_class_range) begin
            band_peak_reg <= band_peak_next; // [RULE4]
            band_sum_reg <= band_sum_next;
        end
    end

    always_ff @(posedge clk) begin
        if (band_done) begin
            band_sums[idx_reg[8:5]] <= band_sum_next;
        end
    end

    // frame totals restart on the first coefficient of each frame
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            energy_reg <= '0;
            total_reg <= '0;
        end else if (in_fire) begin
            energy_reg <= ((idx_reg == '0) ? '0 : energy_reg) + ENERGY_W'(square); // [RULE5]
            if (in_class_range) begin
                total_reg <= ((idx_reg == '0) ? '0 : total_reg) + TOTAL_W'(mag); // [RULE5]
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            kmax_reg <= '0;
            sharp_cnt_reg <= '0;
            noise_cnt_reg <= '0;
        end else if (in_fire && idx_reg == '0) begin
            kmax_reg <= '0;
            sharp_cnt_reg <= '0; // [RULE7]
            noise_cnt_reg <= '0; // [RULE8]
        end else if (band_done) begin
            kmax_reg <= max_mag(kmax_reg, band_peak_next); // [RULE6]
            sharp_cnt_reg <= sharp_cnt_reg + CNT_W'(band_is_sharp); // [RULE7]
            noise_cnt_reg <= noise_cnt_reg + CNT_W'(band_is_noisy); // [RULE8]
        end
    end

    // spread, one band per cycle, scaled by 288
    always_comb begin
        logic [TOTAL_W:0] scaled;
        logic [TOTAL_W:0] tot;
        scaled = (TOTAL_W+1)'(band_sums[spread_idx_reg]) * (TOTAL_W+1)'(SPREAD_BAND_MUL);
        tot = (TOTAL_W+1)'(total_reg);
        spread_term = (scaled > tot) ? SPREAD_W'(scaled - tot) : SPREAD_W'(tot - scaled); // [RULE5]
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_reg <= ST_ACCUM;
            spread_idx_reg <= '0;
            spread_reg <= '0;
        end else begin
            unique case (state_reg)
                ST_ACCUM: begin
                    if (frame_done) begin
                        state_reg <= ST_SPREAD;
                        spread_idx_reg <= '0;
                        spread_reg <= '0;
                    end
                end
                ST_SPREAD: begin
                    spread_reg <= spread_reg + spread_term; // [RULE5]
                    spread_idx_reg <= spread_idx_reg + 4'd1;
                    if (spread_idx_reg == NUM_BANDS - 4'd1) begin
                        state_reg <= ST_DECIDE;
                    end
                end
                ST_DECIDE: begin
                    state_reg <= ST_ACCUM;
                end
            endcase
        end
    end

    // thresholds from the saved history
    always_comb begin
        if (ctrl_reg[CTRL_PREV_SWB_BIT]) begin
            if (prev_class_reg == CLASS_HARMONIC) begin
                isharp = ISHARP_SWB_HARM; // [RULE9]
            end else if (prev_class_reg == CLASS_TRANSIENT) begin
                isharp = ISHARP_SWB_TRANS; // [RULE9]
            end else begin
                isharp = ISHARP_SWB_OTHER; // [RULE9]
            end
            lsharp = LSHARP_SWB; // [RULE10]
        end else begin
            isharp = (prev_class_reg == CLASS_HARMONIC) ? ISHARP_CHG_HARM : ISHARP_CHG_OTHER; // [RULE9]
            lsharp = (prev_class_reg == CLASS_HARMONIC) ? LSHARP_HARM : LSHARP_OTHER; // [RULE10]
        end
    end

    always_comb begin
        logic [ENERGY_W+3:0] cur_lo;
        logic [ENERGY_W+3:0] cur_hi;
        logic [ENERGY_W+3:0] prev_hi;
        logic [SPREAD_W+3:0] spread_scaled;
        logic [SPREAD_W+3:0] mean_scaled;
        cur_lo = (ENERGY_W+4)'(energy_reg) * (ENERGY_W+4)'(RATIO_LO_MUL);
        cur_hi = (ENERGY_W+4)'(energy_reg) * (ENERGY_W+4)'(RATIO_HI_CUR);
        prev_hi = (ENERGY_W+4)'(prev_energy_reg) * (ENERGY_W+4)'(RATIO_HI_PREV);
        spread_scaled = (SPREAD_W+4)'(spread_reg) * (SPREAD_W+4)'(SPREAD_MUL);
        mean_scaled = (SPREAD_W+4)'(total_reg) * (SPREAD_W+4)'(MEAN_MUL);
        // a silent previous frame never passes the ratio test
        ratio_ok = (prev_energy_reg != '0) && (cur_lo > (ENERGY_W+4)'(prev_energy_reg))
            && (cur_hi < prev_hi); // [RULE23] [RULE11]
        harm_hit = (sharp_cnt_reg > isharp) && ratio_ok && (kmax_reg > lsharp); // [RULE11]
        noise_hit = (noise_cnt_reg > NOISE_BANDS_MIN) && (spread_scaled < mean_scaled)
            && (frame_tilt_reg < TILT_LIMIT); // [RULE14]
        if (harm_hit) begin
            persist_next = (persist_reg < PERSIST_MAX) ? persist_reg + 4'd1 : persist_reg; // [RULE11]
        end else begin
            persist_next = (persist_reg != '0) ? persist_reg - 4'd1 : '0; // [RULE12]
        end
        if (frame_transient_reg) begin
            class_next = CLASS_TRANSIENT; // [RULE1]
        end else if (harm_hit || persist_next >= PERSIST_FORCE) begin
            class_next = CLASS_HARMONIC; // [RULE13]
        end else if (noise_hit) begin
            class_next = CLASS_NOISE; // [RULE14]
        end else begin
            class_next = CLASS_NORMAL; // [RULE14]
        end
    end

    // history; a decision beats a same-cycle clear
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            persist_reg <= '0; // [RULE22]
            prev_class_reg <= CLASS_NORMAL; // [RULE22]
            prev_energy_reg <= '0; // [RULE22]
        end else if (state_reg == ST_DECIDE) begin
            if (!frame_transient_reg) begin
                persist_reg <= persist_next; // [RULE1]
            end
            prev_class_reg <= class_next; // [RULE16]
            prev_energy_reg <= energy_reg;
        end else if (hist_clear) begin
            persist_reg <= '0;
            prev_class_reg <= CLASS_NORMAL;
            prev_energy_reg <= '0;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            class_valid <= 1'b0;
            class_code <= CLASS_NORMAL;
            last_trans_reg <= 1'b0;
            frames_reg <= '0;
        end else begin
            class_valid <= (state_reg == ST_DECIDE);
            if (state_reg == ST_DECIDE) begin
                class_code <= class_next; // [RULE15]
                last_trans_reg <= (class_next == CLASS_TRANSIENT);
                frames_reg <= frames_reg + 32'd1;
            end
        end
    end

    // sub-band tables follow the last decided class; offset follows the rate bit
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            hb_offset <= OFFSET_13K2;
            sb_count <= SB_COUNT_NORMAL;
            bound_start <= '0;
            bound_end <= '0;
            map_band <= '0;
        end else begin
            hb_offset <= ctrl_reg[CTRL_RATE_BIT] ? OFFSET_32K : OFFSET_13K2; // [RULE17]
            sb_count <= last_trans_reg ? SB_COUNT_TRANS : SB_COUNT_NORMAL; // [RULE18] [RULE19]
            bound_start <= sb_start(last_trans_reg, bound_sel);
            bound_end <= sb_start(last_trans_reg, bound_sel + 4'd1);
            map_band <= locate(last_trans_reg, map_k); // [RULE20]
        end
    end

    // k past the end maps to the last band
    function automatic logic [3:0] locate(input logic trans, input logic [IDX_W-1:0] k);
        locate = '0;
        for (int j = 1; j < 14; j++) begin
            if (sb_start(trans, 4'(j)) <= k && 4'(j) < (trans ? SB_COUNT_TRANS : SB_COUNT_NORMAL)) begin
                locate = 4'(j); // [RULE20]
            end
        end
    endfunction : locate

    // apb, no wait states; read data loaded in setup
    assign apb_setup = psel && !penable;
    assign apb_write = psel && penable && pwrite && addr_ok;
    assign pready = 1'b1;
    assign addr_ok = (paddr == ADDR_CTRL) || (paddr == ADDR_STATUS) || (paddr == ADDR_ENERGY_LO)
        || (paddr == ADDR_ENERGY_HI) || (paddr == ADDR_PEAK) || (paddr == ADDR_SPREAD)
        || (paddr == ADDR_FRAMES);
    assign pslverr = psel && penable && !addr_ok;
    assign hist_clear = apb_write && (paddr == ADDR_CTRL) && pwdata[CTRL_CLEAR_BIT];

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ctrl_reg <= CTRL_RESET;
        end else if (apb_write && paddr == ADDR_CTRL) begin
            ctrl_reg <= pwdata[1:0];
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            prdata <= '0;
        end else if (apb_setup) begin
            unique case (paddr)
                ADDR_CTRL: prdata <= {30'h0, ctrl_reg};
                ADDR_STATUS: prdata <= {14'h0, state_reg != ST_ACCUM, frame_transient_reg,
                    noise_cnt_reg, sharp_cnt_reg, persist_reg, 2'b00, prev_class_reg};
                ADDR_ENERGY_LO: prdata <= prev_energy_reg[31:0];
                ADDR_ENERGY_HI: prdata <= {24'h0, prev_energy_reg[ENERGY_W-1:32]};
                ADDR_PEAK: prdata <= {16'h0, kmax_reg};
                ADDR_SPREAD: prdata <= spread_reg;
                ADDR_FRAMES: prdata <= frames_reg;
                default: prdata <= '0;
            endcase
        end
    end

endmodule : shb_frame_classifier

/* tb/shb_checker.sv */
// port assertions for the frame classifier
module shb_checker
    import shb_classifier_pkg::*;
(
    input logic clk,
    input logic rstn,
    input logic psel,
    input logic penable,
    input logic pwrite,
    input logic [7:0] paddr,
    input logic [31:0] pwdata,
    input logic in_valid,
    input logic in_ready,
    input logic transient_flag,
    input logic class_valid,
    input logic [1:0] class_code,
    input logic [6:0] hb_offset,
    input logic [3:0] sb_count,
    input logic [IDX_W-1:0] map_k,
    input logic [3:0] map_band
);
    logic [8:0] beat_reg;
    logic trans_reg;
    wire take = in_valid && in_ready;
    wire last = take && beat_reg == 9'd319;
    // beat count ties latency to the last beat
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            beat_reg <= '0;
            trans_reg <= 1'b0;
        end else if (take) begin
            beat_reg <= last ? 9'd0 : beat_reg + 9'd1;
            if (beat_reg == 9'd0) trans_reg <= transient_flag;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    property p_latency; last |-> ##11 class_valid; endproperty
    a_latency: assert property (p_latency) else $error("late class");
    property p_stall; last |=> !in_ready [*8]; endproperty
    a_stall: assert property (p_stall) else $error("beat taken");
    property p_trans; class_valid |-> (class_code == 2'b01) == trans_reg; endproperty
    a_trans: assert property (p_trans) else $error("transient class");
    property p_sbcnt; sb_count == (($past(class_code) == 2'b01) ? 4'd4 : 4'd14); endproperty
    a_sbcnt: assert property (p_sbcnt) else $error("sub-band count");
    property p_hold; $changed(class_code) |-> class_valid; endproperty
    a_hold: assert property (p_hold) else $error("class changed");
    property p_pulse; class_valid |=> !class_valid; endproperty
    a_pulse: assert property (p_pulse) else $error("long valid");
    property p_offset; psel && penable && pwrite && paddr == 8'h00
        |=> ##1 hb_offset == ($past(pwdata[0], 2) ? 7'd80 : 7'd6); endproperty
    a_offset: assert property (p_offset) else $error("offset");
    property p_mapend; map_k >= 9'd320 |=> map_band == sb_count - 4'd1; endproperty
    a_mapend: assert property (p_mapend) else $error("map end");
endmodule : shb_checker

/* tb/coef_source.sv */
// upstream model: one frame of 320 beats per start pulse, with random gaps
module coef_source
    import shb_classifier_pkg::*;
(
    input logic clk,
    input logic rstn,
    input logic start,
    input logic kind,
    input logic flag,
    input logic [15:0] tilt,
    input logic in_ready,
    output logic in_valid,
    output logic signed [COEF_W-1:0] in_coef,
    output logic transient_flag,
    output logic signed [15:0] in_tilt
);
    timeunit 1ns;
    timeprecision 1ps;
    logic busy;
    logic [8:0] n;
    logic [8:0] idx;
    logic act;
    logic [15:0] mag;
    wire take = in_valid && in_ready;
    // kind 1: tall peak heads each band
    always_comb begin
        idx = start ? 9'd0 : n + 9'(take);
        act = start || (busy && !(take && n == 9'd319));
        mag = (kind && idx < 9'd288 && idx[4:0] == 5'd0) ? 16'd100 : 16'd1;
    end
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            busy <= 1'b0;
            n <= '0;
            in_valid <= 1'b0;
            in_coef <= '0;
            transient_flag <= 1'b0;
            in_tilt <= '0;
        end else begin
            busy <= start || (busy && !(take && n == 9'd319));
            n <= idx;
            // beat held until taken; idle lines carry junk
            if (!in_valid || in_ready) begin
                in_valid <= act && ($urandom_range(3) != 0);
                in_coef <= act ? ($urandom_range(1) ? -mag : mag) : 16'($urandom);
                transient_flag <= (act && idx == 9'd0) ? flag : 1'($urandom);
                in_tilt <= (act && idx == 9'd0) ? tilt : 16'($urandom);
            end
        end
    end
endmodule : coef_source

/* tb/shb_frame_classifier_tb.sv */
// self-checking bench for the frame classifier
module shb_frame_classifier_tb;
    import shb_classifier_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0;
    logic rstn = 0;
    logic psel = 0, penable = 0, pwrite = 0, start = 0, kind = 0, flag = 0;
    logic [7:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic pready, pslverr, err, in_valid, in_ready, transient_flag, class_valid;
    logic signed [COEF_W-1:0] in_coef;
    logic signed [15:0] in_tilt;
    logic [15:0] tilt = '0;
    logic [1:0] class_code;
    logic [6:0] hb_offset;
    logic [3:0] sb_count, map_band, bound_sel = '0;
    logic [IDX_W-1:0] bound_start, bound_end, map_k = '0;
    int miscompares = 0, n_tests = 0, cycles = 0;
    always #4 clk = ~clk;
    shb_frame_classifier uut (.*);
    coef_source src (.*);
    function automatic logic [8:0] sbs(input logic tr, input int j);
        int t[5] = '{0, 76, 152, 236, 320};
        int n[15] = '{0, 16, 40, 56, 80, 96, 120, 136, 160, 184, 208, 232, 256, 288, 320};
        sbs = tr ? ((j < 5) ? 9'(t[j]) : 9'd320) : ((j < 15) ? 9'(n[j]) : 9'd320);
    endfunction : sbs
    function automatic logic [3:0] band_of(input logic tr, input logic [8:0] k);
        band_of = '0;
        for (int j = 1; j < (tr ? 4 : 14); j++) if (sbs(tr, j) <= k) band_of = 4'(j);
    endfunction : band_of
    task automatic compare(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : compare
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : complete_run
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int t;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        t = 0;
        do begin
            @(posedge clk);
            t++;
        end while (pready !== 1'b1 && t < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        apb(1'b0, a, '0);
        compare(rd & m, e);
    endtask : rdchk
    task automatic frame(input logic h, input logic f, input logic [15:0] tl, input logic [1:0] ec);
        int t;
        kind <= h;
        flag <= f;
        tilt <= tl;
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        t = 0;
        do begin
            @(posedge clk);
            t++;
        end while (class_valid !== 1'b1 && t < 3000);
        compare(class_code, ec);
    endtask : frame
    // last entry: index past frame end
    task automatic look(input logic tr);
        for (int j = 0; j < 15; j++) begin
            bound_sel <= 4'(j);
            map_k <= (j == 14) ? 9'h1ff : 9'($urandom_range(319));
            @(posedge clk);
            @(posedge clk);
            compare(bound_start, sbs(tr, j));
            compare(bound_end, sbs(tr, j + 1));
            compare(map_band, band_of(tr, map_k));
        end
    endtask : look
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            complete_run;
        end
    end
    initial begin
        void'($urandom(32'hc6dcc76c));
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        rdchk(ADDR_CTRL, '1, 32'h0);
        rdchk(ADDR_STATUS, 32'hff, 32'h02);
        apb(1'b0, 8'h40, '0);
        compare({rd[30:0], err}, 32'h1);
        for (int r = 1; r >= 0; r--) begin
            apb(1'b1, ADDR_CTRL, 32'(r));
            repeat (2) @(negedge clk);
            compare(hb_offset, r ? 32'd80 : 32'd6);
        end
        frame(1'b0, 1'b1, 16'h7fff, CLASS_TRANSIENT);
        rdchk(ADDR_STATUS, 32'h10003, 32'h10001);
        rdchk(ADDR_ENERGY_LO, '1, 32'd320);
        look(1'b1);
        frame(1'b0, 1'b0, 16'($urandom_range(16'h04ff)), CLASS_NOISE);
        rdchk(ADDR_STATUS, 32'hffff, 32'h9000);
        frame(1'b0, 1'b0, 16'h0500, CLASS_NORMAL);
        look(1'b0);
        frame(1'b1, 1'b0, 16'h0, CLASS_NORMAL);
        repeat (3) frame(1'b1, 1'b0, 16'h0, CLASS_HARMONIC);
        rdchk(ADDR_STATUS, 32'hffff, 32'h0933);
        rdchk(ADDR_PEAK, '1, 32'd100);
        rdchk(ADDR_SPREAD, '1, 32'd0);
        frame(1'b0, 1'b0, 16'h0, CLASS_HARMONIC);
        frame(1'b0, 1'b0, 16'h0, CLASS_NOISE);
        rdchk(ADDR_STATUS, 32'hf0, 32'h10);
        apb(1'b1, ADDR_CTRL, 32'h4);
        rdchk(ADDR_STATUS, 32'hf3, 32'h02);
        complete_run;
    end
endmodule : shb_frame_classifier_tb
bind shb_frame_classifier shb_checker u_chk (.*);
